// ==== verilog/bmp_regs.sv ====
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bmp_regs (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address, low bits
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic [2:0] mode_strap, // mode pins, caught after reset
  input wire logic secure_mode, // chip is secured
  input wire bmp_pkg::bmp_port8_t port_dir, // 1 = pin is output
  output bmp_pkg::bmp_port8_t pull_en, // per-pin pull enables
  output logic [2:0] mode_select_field, // current mode
  output logic internal_visibility, // internal cycles shown outside
  output logic port_k_regs_mapped, // port k data/dir on chip
  output logic port_e_regs_mapped, // port e data/dir on chip
  output logic regs_on_chip, // this bank decoded on chip
  output logic ext_echo // access passed to external bus
);

  logic boot_ff;
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] pull_reg_ff, nxt_pull_reg;
  logic done_ff, nxt_done;
  logic pend_ff;
  logic [7:0] pend_data_ff;
  logic dp_mode_wr_ff, dp_pull_wr_ff;
  logic [31:0] hrdata_ff;
  logic echo_ff, kmap_ff, emap_ff, onchip_ff;
  bmp_pkg::bmp_port8_t pull_ff, nxt_pull;

  logic take, hit_mode, hit_pull, on_chip;
  logic [2:0] cur, req;
  logic is_spec, is_emu, is_norm, mode_ok;

  assign take = hsel && hready && htrans[1];
  assign hit_mode = haddr == bmp_pkg::MODE_ADDR;
  assign hit_pull = haddr == bmp_pkg::PULL_ADDR;
  assign on_chip = bmp_pkg::single_chip(mode_ff[7:5]);
  assign cur = mode_ff[7:5];
  assign req = pend_data_ff[7:5];
  assign is_spec = bmp_pkg::special_mode(cur);
  assign is_emu = !cur[2] && cur[0];
  assign is_norm = cur[2] && (cur != bmp_pkg::M_PERIPH);

  // decides whether the mode field may take the pending value
  always_comb begin
    mode_ok = 1'b0;
    if (!secure_mode && !cur[0] && cur != bmp_pkg::M_PERIPH) begin
      if (is_spec) begin
        mode_ok = req != bmp_pkg::M_PERIPH;
      end else begin
        mode_ok = !done_ff && req[2] && req != bmp_pkg::M_PERIPH;
      end
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    nxt_done = done_ff;
    if (boot_ff) begin
      nxt_mode = bmp_pkg::MODE_RST[mode_strap];
      nxt_done = 1'b0;
    end else if (pend_ff) begin
      if (mode_ok) begin
        nxt_mode[7:5] = req;
      end
      if (is_spec || (is_norm && !done_ff)) begin
        nxt_mode[bmp_pkg::INTERNAL_VISIBILITY_BIT] = pend_data_ff[bmp_pkg::INTERNAL_VISIBILITY_BIT];
        nxt_mode[bmp_pkg::EMK_BIT] = pend_data_ff[bmp_pkg::EMK_BIT];
      end
      if (is_spec) begin
        nxt_mode[bmp_pkg::EME_BIT] = pend_data_ff[bmp_pkg::EME_BIT];
      end
      if (is_norm) begin
        nxt_done = 1'b1;
      end else if (is_spec && mode_ok) begin
        nxt_done = req != bmp_pkg::M_NORM_SC;
      end
    end
    nxt_mode = nxt_mode & bmp_pkg::MODE_MASK;
  end

  always_comb begin
    nxt_pull_reg = pull_reg_ff;
    if (dp_pull_wr_ff) begin
      nxt_pull_reg = hwdata[7:0] & bmp_pkg::PULL_MASK;
    end
  end

  // pulls only on input pins
  for (genvar i = 0; i < 8; i++) begin : g_pull
    assign nxt_pull.k[i] = nxt_pull_reg[bmp_pkg::PULL_K_BIT] && !port_dir.k[i];
    assign nxt_pull.b[i] = nxt_pull_reg[bmp_pkg::PULL_B_BIT] && !port_dir.b[i];
    assign nxt_pull.a[i] = nxt_pull_reg[bmp_pkg::PULL_A_BIT] && !port_dir.a[i];
    if (i == 5 || i == 6) begin : g_e_rst
      assign nxt_pull.e[i] = 1'b0;
    end else begin : g_e_sw
      assign nxt_pull.e[i] = nxt_pull_reg[bmp_pkg::PULL_E_BIT] && !port_dir.e[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_ff <= 1'b1;
      mode_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      mode_ff <= nxt_mode;
      done_ff <= nxt_done;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_reg_ff <= bmp_pkg::PULL_RESET;
      pull_ff <= {8'h00, bmp_pkg::PULL_E_RESET, 8'h00, 8'h00};
    end else begin
      pull_reg_ff <= nxt_pull_reg;
      pull_ff <= nxt_pull;
    end
  end

  // write data is held one cycle before it reaches the mode register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
      pend_data_ff <= 8'h00;
    end else begin
      pend_ff <= dp_mode_wr_ff;
      if (dp_mode_wr_ff) begin
        pend_data_ff <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_mode_wr_ff <= 1'b0;
      dp_pull_wr_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      echo_ff <= 1'b0;
    end else begin
      dp_mode_wr_ff <= take && hwrite && hit_mode && on_chip;
      dp_pull_wr_ff <= take && hwrite && hit_pull && on_chip;
      echo_ff <= take && (hit_mode || hit_pull) && !on_chip;
      if (take && !hwrite) begin
        if (on_chip && hit_mode) begin
          hrdata_ff <= {24'h00_0000, mode_ff};
        end else if (on_chip && hit_pull) begin
          hrdata_ff <= {24'h00_0000, pull_reg_ff};
        end else begin
          hrdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kmap_ff <= 1'b1;
      emap_ff <= 1'b1;
      onchip_ff <= 1'b1;
    end else begin
      onchip_ff <= bmp_pkg::single_chip(nxt_mode[7:5]);
      kmap_ff <= bmp_pkg::single_chip(nxt_mode[7:5]) ||
                 (nxt_mode[5] && !nxt_mode[bmp_pkg::EMK_BIT]);
      emap_ff <= bmp_pkg::single_chip(nxt_mode[7:5]) ||
                 !nxt_mode[bmp_pkg::EME_BIT];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign pull_en = pull_ff;
  assign mode_select_field = mode_ff[7:5];
  assign internal_visibility = mode_ff[bmp_pkg::INTERNAL_VISIBILITY_BIT];
  assign port_k_regs_mapped = kmap_ff;
  assign port_e_regs_mapped = emap_ff;
  assign regs_on_chip = onchip_ff;
  assign ext_echo = echo_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_low_bit_locks;
    !boot_ff && pend_ff && cur[0] |=> mode_ff[7:5] == $past(mode_ff[7:5]);
  endproperty
  a_low_bit_locks: assert property (p_low_bit_locks) else $error("mode changed while locked");

  property p_no_periph;
    !boot_ff && pend_ff && is_spec && req == bmp_pkg::M_PERIPH |=> mode_ff[7:5] == $past(cur);
  endproperty
  a_no_periph: assert property (p_no_periph) else $error("entered peripheral mode");

  property p_secure;
    !boot_ff && pend_ff && secure_mode |=> $stable(mode_ff[7:5]);
  endproperty
  a_secure: assert property (p_secure) else $error("mode written while secure");

  property p_delay;
    dp_mode_wr_ff && !pend_ff && !boot_ff |=> $stable(mode_ff) ##1 (mode_ff == $past(nxt_mode));
  endproperty
  a_delay: assert property (p_delay) else $error("mode write not delayed one cycle");

  property p_norm_once;
    !boot_ff && pend_ff && cur == bmp_pkg::M_NORM_SC && !done_ff && !secure_mode &&
    (req == bmp_pkg::M_NORM_NAR || req == bmp_pkg::M_NORM_WIDE) |=> mode_ff[7:5] == $past(req) && done_ff;
  endproperty
  a_norm_once: assert property (p_norm_once) else $error("normal single chip write lost");

  property p_one_left;
    !boot_ff && pend_ff && is_spec && !secure_mode && req == bmp_pkg::M_NORM_SC |=> !done_ff;
  endproperty
  a_one_left: assert property (p_one_left) else $error("no write left after special");

  property p_echo;
    take && hit_pull && !on_chip |=> ext_echo ##1 (hrdata == 32'h0000_0000 || $past(hwrite, 2));
  endproperty
  a_echo: assert property (p_echo) else $error("off-chip access not echoed");

  property p_pull_e_rst;
    !boot_ff |-> pull_en.e[6:5] == 2'b00;
  endproperty
  a_pull_e_rst: assert property (p_pull_e_rst) else $error("port e pins 5,6 pulled after reset");

  property p_pull_out;
    !boot_ff ##1 port_dir.k[0] |=> !pull_en.k[0];
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull active on output pin");

  // bit 2 is unimplemented in both registers
  property p_upper_zero;
    hrdata[31:8] == 24'h00_0000 && hrdata[2] == 1'b0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unimplemented read bits set");

  property p_mode_read;
    take && !hwrite && hit_mode && on_chip |=> hrdata == {24'h00_0000, $past(mode_ff)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read data wrong");

  property p_off_read_zero;
    take && !hwrite && !(on_chip && (hit_mode || hit_pull)) |=> hrdata == 32'h0000_0000;
  endproperty
  a_off_read_zero: assert property (p_off_read_zero) else $error("undecoded read not zero");

  property p_echo_mode;
    take && hit_mode && !on_chip |=> ext_echo;
  endproperty
  a_echo_mode: assert property (p_echo_mode) else $error("off-chip mode access not echoed");

  property p_no_echo;
    !(take && (hit_mode || hit_pull) && !on_chip) |=> !ext_echo;
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("echo without off-chip access");

  property p_no_wr_off;
    take && !on_chip |=> !dp_mode_wr_ff && !dp_pull_wr_ff;
  endproperty
  a_no_wr_off: assert property (p_no_wr_off) else $error("write taken while off chip");

  property p_periph_hold;
    !boot_ff && cur == bmp_pkg::M_PERIPH |=> $stable(mode_ff);
  endproperty
  a_periph_hold: assert property (p_periph_hold) else $error("peripheral mode register changed");

  property p_emu_lock;
    !boot_ff && is_emu |=> $stable(mode_ff);
  endproperty
  a_emu_lock: assert property (p_emu_lock) else $error("emulation mode register changed");

  property p_norm_no_top;
    !boot_ff && cur == bmp_pkg::M_NORM_SC |=> mode_ff[7];
  endproperty
  a_norm_no_top: assert property (p_norm_no_top) else $error("top mode bit cleared");

  property p_maps_single;
    regs_on_chip |-> port_k_regs_mapped && port_e_regs_mapped;
  endproperty
  a_maps_single: assert property (p_maps_single) else $error("port regs unmapped in single chip");

  property p_kmap_periph;
    !boot_ff && mode_select_field == bmp_pkg::M_PERIPH |-> !port_k_regs_mapped;
  endproperty
  a_kmap_periph: assert property (p_kmap_periph) else $error("port k mapped in peripheral");

  property p_emap_off;
    !boot_ff && !regs_on_chip && mode_ff[bmp_pkg::EME_BIT] |-> !port_e_regs_mapped;
  endproperty
  a_emap_off: assert property (p_emap_off) else $error("port e mapped while emulated");

  property p_on_chip;
    !boot_ff |-> regs_on_chip == (mode_select_field == bmp_pkg::M_SPEC_SC ||
      mode_select_field == bmp_pkg::M_SPEC_TEST || mode_select_field == bmp_pkg::M_NORM_SC);
  endproperty
  a_on_chip: assert property (p_on_chip) else $error("on-chip decode wrong for mode");

  property p_done_norm;
    !boot_ff && pend_ff && is_norm |=> done_ff;
  endproperty
  a_done_norm: assert property (p_done_norm) else $error("normal write did not use once");

  property p_to_exp_done;
    !boot_ff && pend_ff && is_spec && !secure_mode && req[0] |=> done_ff;
  endproperty
  a_to_exp_done: assert property (p_to_exp_done) else $error("writes left after expanded");

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");

  property p_pull_wr;
    dp_pull_wr_ff |=> pull_reg_ff == ($past(hwdata[7:0]) & bmp_pkg::PULL_MASK);
  endproperty
  a_pull_wr: assert property (p_pull_wr) else $error("pull write lost");

  property p_mode_pend;
    dp_mode_wr_ff |=> pend_ff && pend_data_ff == $past(hwdata[7:0]);
  endproperty
  a_mode_pend: assert property (p_mode_pend) else $error("mode write not held");

  property p_no_pend;
    !boot_ff && !pend_ff |=> $stable(mode_ff);
  endproperty
  a_no_pend: assert property (p_no_pend) else $error("mode changed without write");

  property p_spec_internal_visibility;
    !boot_ff && pend_ff && is_spec |=> internal_visibility == $past(pend_data_ff[bmp_pkg::INTERNAL_VISIBILITY_BIT]);
  endproperty
  a_spec_internal_visibility: assert property (p_spec_internal_visibility) else $error("special visibility write lost");

  property p_norm_once_low;
    !boot_ff && pend_ff && is_norm && done_ff |=> $stable(mode_ff[3:0]);
  endproperty
  a_norm_once_low: assert property (p_norm_once_low) else $error("second normal write taken");

  property p_eme_norm;
    !boot_ff && pend_ff && !is_spec |=> $stable(mode_ff[bmp_pkg::EME_BIT]);
  endproperty
  a_eme_norm: assert property (p_eme_norm) else $error("port e emulation written outside special");

  property p_pull_k;
    !boot_ff |=> pull_en.k == ({8{pull_reg_ff[bmp_pkg::PULL_K_BIT]}} & ~$past(port_dir.k));
  endproperty
  a_pull_k: assert property (p_pull_k) else $error("port k pulls wrong");

  property p_pull_e;
    !boot_ff |=> {pull_en.e[7], pull_en.e[4:0]} ==
      ({6{pull_reg_ff[bmp_pkg::PULL_E_BIT]}} & ~$past({port_dir.e[7], port_dir.e[4:0]}));
  endproperty
  a_pull_e: assert property (p_pull_e) else $error("port e pulls wrong");

  property p_pull_b;
    !boot_ff |=> pull_en.b == ({8{pull_reg_ff[bmp_pkg::PULL_B_BIT]}} & ~$past(port_dir.b));
  endproperty
  a_pull_b: assert property (p_pull_b) else $error("port b pulls wrong");

  property p_pull_a;
    !boot_ff |=> pull_en.a == ({8{pull_reg_ff[bmp_pkg::PULL_A_BIT]}} & ~$past(port_dir.a));
  endproperty
  a_pull_a: assert property (p_pull_a) else $error("port a pulls wrong");

endmodule
`default_nettype wire

// ==== common/bmp_pkg.sv ====
// How it works
// - mode field bits 7:5 shows the current mode, eight encodings, peripheral is 110
// - when the low mode bit is 1 writes to the mode field are ignored
// - special single chip or special test: mode writable, never to or from 110
// - normal single chip: top bit fixed, low two bits once, only to expanded
// - secure state blocks every write to the mode field
// - special to normal single chip leaves one write; to expanded or emulation none
// - mode register writes take effect one cycle after the write
// - peripheral mode: mode register inaccessible but holds its reset values
// - bit 3 internal visibility: once normal, never emulation, anytime special
// - bit 1 removes port K registers in expanded modes; fixed per mode otherwise
// - bit 0 removes port E registers in expanded or peripheral; special-only write
// - expanded and peripheral modes: registers not decoded, accesses echoed out
// - pull register read and write anytime while mapped
// - pulls act per port and only on pins that are inputs
// - pull bit 7 enables port K input pulls
// - pull bit 4 enables port E pins 7 and 4:0; pins 5 and 6 only in reset
// - pull bit 1 port B, bit 0 port A input pulls
package bmp_pkg;

  localparam logic [3:0] MODE_IDX = 4'hB;
  localparam logic [3:0] PULL_IDX = 4'hC;
  localparam logic [7:0] MODE_ADDR = {2'b00, MODE_IDX, 2'b00};
  localparam logic [7:0] PULL_ADDR = {2'b00, PULL_IDX, 2'b00};

  localparam logic [7:0] MODE_MASK = 8'hEB;
  localparam logic [7:0] PULL_MASK = 8'h93;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] PULL_E_RESET = 8'h60;

  localparam int MODE_LSB = 5;
  localparam int INTERNAL_VISIBILITY_BIT = 3;
  localparam int EMK_BIT = 1;
  localparam int EME_BIT = 0;
  localparam int PULL_K_BIT = 7;
  localparam int PULL_E_BIT = 4;
  localparam int PULL_B_BIT = 1;
  localparam int PULL_A_BIT = 0;

  localparam logic [2:0] M_SPEC_SC = 3'h0;
  localparam logic [2:0] M_EMU_NAR = 3'h1;
  localparam logic [2:0] M_SPEC_TEST = 3'h2;
  localparam logic [2:0] M_EMU_WIDE = 3'h3;
  localparam logic [2:0] M_NORM_SC = 3'h4;
  localparam logic [2:0] M_NORM_NAR = 3'h5;
  localparam logic [2:0] M_PERIPH = 3'h6;
  localparam logic [2:0] M_NORM_WIDE = 3'h7;

  localparam logic [7:0] MODE_RST [8] = '{8'h00, 8'h2B, 8'h48, 8'h6B,
                                          8'h80, 8'hA0, 8'hC0, 8'hE0};

  typedef struct packed {
    logic [7:0] k;
    logic [7:0] e;
    logic [7:0] b;
    logic [7:0] a;
  } bmp_port8_t;

  function automatic logic single_chip(input logic [2:0] m);
    return !m[0] && (m != M_PERIPH);
  endfunction

  function automatic logic special_mode(input logic [2:0] m);
    return !m[0] && !m[2];
  endfunction

endpackage

// ==== dv/tb_bus_mode_and_pull_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_bus_mode_and_pull_control;
  logic hclk, hresetn, hsel, hwrite, secure_mode;
  logic hreadyout, hresp, internal_visibility, echo;
  logic port_k_regs_mapped, port_e_regs_mapped, regs_on_chip, ext_echo;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, mode_strap, mode_select_field;
  logic [31:0] hwdata, hrdata;
  bmp_pkg::bmp_port8_t port_dir, pull_en;
  int err_count = 0;
  int compares = 0;

  bmp_regs dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mode_strap(mode_strap),
    .secure_mode(secure_mode), .port_dir(port_dir), .pull_en(pull_en),
    .mode_select_field(mode_select_field), .internal_visibility(internal_visibility),
    .port_k_regs_mapped(port_k_regs_mapped), .port_e_regs_mapped(port_e_regs_mapped),
    .regs_on_chip(regs_on_chip), .ext_echo(ext_echo)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // bounded wait for the slave to accept the current phase
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
    r = hrdata[7:0];
    echo = ext_echo;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] r;
    bus(a, 1'b0, 8'h00, r);
    `CHK(n, e, r)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // mode write: old value still shows just after the data phase, new value one cycle later
  task automatic wmode(input logic [7:0] d, input logic [2:0] o, input logic [2:0] nw);
    wr(bmp_pkg::MODE_ADDR, d);
    #1;
    `CHK("mode_old", o, mode_select_field)
    @(posedge hclk);
    #1;
    `CHK("mode_new", nw, mode_select_field)
  endtask

  task automatic rst(input logic [2:0] s);
    mode_strap <= s;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    `CHK("pull_e_rst", 8'h60, pull_en.e)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  task automatic t_reset;
    logic on;
    for (int s = 0; s < 8; s++) begin
      rst(s[2:0]);
      on = (s == 0 || s == 2 || s == 4);
      `CHK("mode_rst", s[2:0], mode_select_field)
      `CHK("on_chip", on, regs_on_chip)
      rd(bmp_pkg::MODE_ADDR, on ? bmp_pkg::MODE_RST[s] : 8'h00, "mode_reg");
      `CHK("echo", !on, echo)
    end
    $display("t_reset done");
  endtask

  task automatic t_special;
    rst(3'h0);
    wmode(8'hC0, 3'h0, 3'h0);
    wmode(8'h40, 3'h0, 3'h2);
    wmode(8'h8B, 3'h2, 3'h4);
    rd(bmp_pkg::MODE_ADDR, 8'h8B, "mode_8b");
    wmode(8'hA0, 3'h4, 3'h5);
    `CHK("internal_visibility", 1'b0, internal_visibility)
    `CHK("e_map", 1'b0, port_e_regs_mapped)
    `CHK("k_map", 1'b1, port_k_regs_mapped)
    `CHK("on_chip", 1'b0, regs_on_chip)
    $display("t_special done");
  endtask

  task automatic t_once;
    rst(3'h4);
    wmode(8'h88, 3'h4, 3'h4);
    rd(bmp_pkg::MODE_ADDR, 8'h88, "mode_88");
    wmode(8'hA0, 3'h4, 3'h4);
    wmode(8'hC0, 3'h4, 3'h4);
    rd(bmp_pkg::MODE_ADDR, 8'h88, "mode_once");
    $display("t_once done");
  endtask

  task automatic t_secure;
    rst(3'h0);
    secure_mode <= 1'b1;
    wmode(8'h48, 3'h0, 3'h0);
    rd(bmp_pkg::MODE_ADDR, 8'h08, "mode_sec");
    secure_mode <= 1'b0;
    $display("t_secure done");
  endtask

  task automatic t_pull;
    rst(3'h0);
    port_dir <= {8'h0F, 8'h00, 8'hFF, 8'h00};
    wr(bmp_pkg::PULL_ADDR, 8'hFF);
    rd(bmp_pkg::PULL_ADDR, 8'h93, "pull_reg");
    `CHK("pull_k", 8'hF0, pull_en.k)
    `CHK("pull_e", 8'h9F, pull_en.e)
    `CHK("pull_b", 8'h00, pull_en.b)
    `CHK("pull_a", 8'hFF, pull_en.a)
    wr(bmp_pkg::PULL_ADDR, 8'h00);
    @(posedge hclk);
    `CHK("pull_a_off", 8'h00, pull_en.a)
    rd(8'h34, 8'h00, "unmapped");
    $display("t_pull done");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 8'h00;
    hwdata = 32'h00000000;
    secure_mode = 1'b0;
    mode_strap = 3'h0;
    port_dir = '0;
    t_reset();
    t_special();
    t_once();
    t_secure();
    t_pull();
    test_done();
  end
endmodule
`default_nettype wire
